// ### hw/bar_action_code.sv
// Bus-sizing action code encoder used while a DMA or master owns the bus.
// Assumes the two address enables are synchronous, active high.
`include "bar_map.svh"
`default_nettype none

module bar_action_code
  import bar_pkg::*;
(
  // DMA address enables and direction
  input wire logic i_dma_addr_en_one,
  input wire logic i_dma_addr_en_two,
  input wire logic i_dma_mem_write,
  // Encoded code pair {bit1,bit0}
  output logic [1:0] o_code
);

  // Enable two with enable one low marks a 16-bit channel whose odd byte needs copying
  always_comb
  begin
    if (i_dma_addr_en_two && !i_dma_addr_en_one)
    begin
      o_code = i_dma_mem_write ? `BAR_AC_HI_WRITE : `BAR_AC_HI_READ;
    end
    else
    begin
      o_code = `BAR_AC_TRISTATE;
    end
  end

endmodule : bar_action_code

`default_nettype wire

// ### hw/bar_arbiter.sv
// Bus arbiter between processor, DMA or bus masters and DRAM refresh.
// Assumes processor acknowledge and DMA request are synchronous to i_ref_clk.
`include "bar_map.svh"
`default_nettype none

module bar_arbiter
  import bar_pkg::*;
#(
  parameter int ROW_W = `BAR_ROW_W
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Processor side
  input wire logic i_cpu_bus_grant,
  input wire logic i_cpu_exp_cycle,
  output logic o_dma_bus_request,
  // DMA or bus-master side
  input wire logic i_dma_hold_req,
  input wire logic i_dma_addr_en_one,
  input wire logic i_dma_addr_en_two,
  input wire logic i_dma_mem_write,
  output logic o_dma_hold_ack,
  // Refresh side
  input wire logic i_refresh_req_n,
  output logic o_refresh_active_n,
  // DRAM and expansion memory
  output logic o_dram_write_en_n,
  output logic o_exp_mem_read_n,
  output logic o_addr_drive,
  output logic [ROW_W-1:0] o_local_mem_addr,
  output logic [ROW_W-1:0] o_exp_bus_addr_low,
  output logic o_row_strobe0_n,
  output logic o_row_strobe1_n,
  output logic o_row_strobe2_n,
  output logic o_row_strobe3_n,
  // Bus sizing
  output logic o_action_code_bit0,
  output logic o_action_code_bit1,
  output logic o_action_code_en_n,
  output logic o_addr_latch_en,
  output logic o_ext_addr_latch_en
);

  // Loads are one short: the loading edge already starts the phase
  localparam logic [`BAR_CNT_W-1:0] SETUP_CYC = `BAR_CNT_W'(`BAR_ADDR_SETUP_CYC - 1);
  localparam logic [`BAR_CNT_W-1:0] STAG_CYC = `BAR_CNT_W'(`BAR_STAGGER_CYC - 1);
  localparam logic [`BAR_CNT_W-1:0] ACT_CYC = `BAR_CNT_W'(`BAR_RAS_ACTIVE_CYC - 1);
  localparam logic [`BAR_CNT_W-1:0] REL_CYC = `BAR_CNT_W'(`BAR_RAS_RELEASE_CYC - 1);
  localparam logic [`BAR_CNT_W-1:0] ONE = `BAR_CNT_W'(1);

  bar_state_all_t s_q;
  bar_state_all_t s_d;
  logic ref_pend;
  logic ref_taken;
  logic [1:0] dma_code;
  logic cnt_done;

  bar_req_latch u_ref_latch (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_req_n(i_refresh_req_n),
    .i_taken(ref_taken),
    .o_pending(ref_pend)
  );

  bar_action_code u_ac (
    .i_dma_addr_en_one(i_dma_addr_en_one),
    .i_dma_addr_en_two(i_dma_addr_en_two),
    .i_dma_mem_write(i_dma_mem_write),
    .o_code(dma_code)
  );

  assign cnt_done = (s_q.cnt == '0);
  assign ref_taken = (s_q.st == BAR_WAIT_ACK) && i_cpu_bus_grant && (s_q.own == BAR_OWN_REF);

  always_comb
  begin
    s_d = s_q;
    s_d.refresh_pend = ref_pend;
    if (!cnt_done)
    begin
      s_d.cnt = s_q.cnt - ONE;
    end
    case (s_q.st)
      BAR_IDLE:
      begin
        // Strobes idle high, so precharge is met before any refresh
        s_d.ras = '1;
        if (ref_pend)
        begin
          s_d.own = BAR_OWN_REF;
          s_d.dma_bus_request = 1'b1;
          s_d.st = BAR_WAIT_ACK;
        end
        else if (i_dma_hold_req)
        begin
          s_d.own = BAR_OWN_DMA;
          s_d.dma_bus_request = 1'b1;
          s_d.st = BAR_WAIT_ACK;
        end
      end
      BAR_WAIT_ACK:
      begin
        // Owner fixed at request time; a later request waits its turn
        if (i_cpu_bus_grant)
        begin
          if (s_q.own == BAR_OWN_REF)
          begin
            s_d.refresh_active_n = 1'b0;
            s_d.dram_write_en_n = 1'b1;
            s_d.addr_drive = 1'b1;
            s_d.cnt = SETUP_CYC;
            s_d.st = BAR_REF_ADDR;
          end
          else if (i_dma_hold_req)
          begin
            s_d.dma_hold_ack = 1'b1;
            s_d.st = BAR_DMA;
          end
          else
          begin
            // Request withdrawn before grant
            s_d.dma_bus_request = 1'b0;
            s_d.st = BAR_RELEASE;
          end
        end
      end
      BAR_REF_ADDR:
      begin
        if (cnt_done)
        begin
          s_d.exp_mem_read_n = 1'b0;
          s_d.ras.row_strobe0_n = 1'b0;
          s_d.ras.row_strobe3_n = 1'b0;
          s_d.cnt = STAG_CYC;
          s_d.st = BAR_REF_RAS_A;
        end
      end
      BAR_REF_RAS_A:
      begin
        if (cnt_done)
        begin
          s_d.ras = '0;
          s_d.cnt = ACT_CYC;
          s_d.st = BAR_REF_RAS_B;
        end
      end
      BAR_REF_RAS_B:
      begin
        if (cnt_done)
        begin
          s_d.exp_mem_read_n = 1'b1;
          s_d.cnt = REL_CYC;
          s_d.st = BAR_REF_END;
        end
      end
      BAR_REF_END:
      begin
        if (cnt_done)
        begin
          // Strobes rise, then hold and refresh active drop next
          if (!(&s_q.ras))
          begin
            s_d.ras = '1;
            s_d.cnt = REL_CYC;
          end
          else
          begin
            s_d.dma_bus_request = 1'b0;
            s_d.refresh_active_n = 1'b1;
            s_d.addr_drive = 1'b0;
            s_d.row = s_q.row + `BAR_ROW_W'(1);
            s_d.st = BAR_RELEASE;
          end
        end
      end
      BAR_DMA:
      begin
        if (!i_dma_hold_req)
        begin
          s_d.dma_bus_request = 1'b0;
          s_d.st = BAR_RELEASE;
        end
      end
      BAR_RELEASE:
      begin
        // Processor takes back the bus once its acknowledge falls
        if (!i_cpu_bus_grant)
        begin
          s_d.dma_hold_ack = 1'b0;
          s_d.own = BAR_OWN_NONE;
          s_d.st = BAR_IDLE;
        end
      end
      default:
      begin
        s_d.st = BAR_IDLE;
      end
    endcase
    // Sizing outputs follow the bus owner each cycle
    if (s_d.st == BAR_DMA || (s_d.st == BAR_RELEASE && s_d.own == BAR_OWN_DMA))
    begin
      s_d.ac.action_code_en_n = 1'b0;
      s_d.ac.addr_latch_en = 1'b1;
      s_d.ac.ext_addr_latch_en = 1'b1;
      {s_d.ac.action_code_bit1, s_d.ac.action_code_bit0} = dma_code;
    end
    else
    begin
      s_d.ac.action_code_en_n = !(i_cpu_exp_cycle && s_d.st == BAR_IDLE);
      s_d.ac.addr_latch_en = 1'b0;
      s_d.ac.ext_addr_latch_en = 1'b0;
      s_d.ac.action_code_bit1 = 1'b0;
      s_d.ac.action_code_bit0 = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      s_q.st <= BAR_IDLE;
      s_q.own <= BAR_OWN_NONE;
      s_q.cnt <= '0;
      s_q.row <= `BAR_ROW_RST;
      s_q.refresh_pend <= 1'b0;
      s_q.dma_bus_request <= 1'b0;
      s_q.refresh_active_n <= 1'b1;
      s_q.dma_hold_ack <= 1'b0;
      s_q.exp_mem_read_n <= 1'b1;
      s_q.dram_write_en_n <= 1'b1;
      s_q.addr_drive <= 1'b0;
      s_q.ras <= '1;
      s_q.ac <= 5'h04;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_dma_bus_request = s_q.dma_bus_request;
  assign o_dma_hold_ack = s_q.dma_hold_ack;
  assign o_refresh_active_n = s_q.refresh_active_n;
  assign o_dram_write_en_n = s_q.dram_write_en_n;
  assign o_exp_mem_read_n = s_q.exp_mem_read_n;
  assign o_addr_drive = s_q.addr_drive;
  assign o_local_mem_addr = s_q.row;
  assign o_exp_bus_addr_low = s_q.row;
  assign o_row_strobe0_n = s_q.ras.row_strobe0_n;
  assign o_row_strobe1_n = s_q.ras.row_strobe1_n;
  assign o_row_strobe2_n = s_q.ras.row_strobe2_n;
  assign o_row_strobe3_n = s_q.ras.row_strobe3_n;
  assign o_action_code_bit0 = s_q.ac.action_code_bit0;
  assign o_action_code_bit1 = s_q.ac.action_code_bit1;
  assign o_action_code_en_n = s_q.ac.action_code_en_n;
  assign o_addr_latch_en = s_q.ac.addr_latch_en;
  assign o_ext_addr_latch_en = s_q.ac.ext_addr_latch_en;

endmodule : bar_arbiter

`default_nettype wire

// ### hw/bar_map.svh
// Constants for the bus arbiter with refresh and DMA hand-off.
// Assumes inclusion by bar_pkg, the design modules and the bench.
`ifndef BAR_MAP_SVH
`define BAR_MAP_SVH

`define BAR_ROW_W 10
`define BAR_ROW_RST 10'h000
`define BAR_CLK_NS 8
// Refresh phase lengths in ns and derived cycle counts (least times round up)
`define BAR_ADDR_SETUP_NS 16
`define BAR_STAGGER_NS 16
`define BAR_RAS_ACTIVE_NS 80
`define BAR_RAS_RELEASE_NS 16
`define BAR_ADDR_SETUP_CYC ((`BAR_ADDR_SETUP_NS + `BAR_CLK_NS - 1) / `BAR_CLK_NS)
`define BAR_STAGGER_CYC ((`BAR_STAGGER_NS + `BAR_CLK_NS - 1) / `BAR_CLK_NS)
`define BAR_RAS_ACTIVE_CYC ((`BAR_RAS_ACTIVE_NS + `BAR_CLK_NS - 1) / `BAR_CLK_NS)
`define BAR_RAS_RELEASE_CYC ((`BAR_RAS_RELEASE_NS + `BAR_CLK_NS - 1) / `BAR_CLK_NS)
`define BAR_CNT_W 4
// Action codes during DMA or master cycles {bit1,bit0}
`define BAR_AC_TRISTATE 2'h0
`define BAR_AC_RESERVED 2'h1
`define BAR_AC_HI_WRITE 2'h2
`define BAR_AC_HI_READ 2'h3

`endif

// ### hw/bar_pkg.sv
// Types for the bus arbiter: states, strobe bundles and arbiter state.
// Assumes bar_map.svh is on the include path.
`include "bar_map.svh"
`default_nettype none

package bar_pkg;

  typedef enum logic [7:0] {
    BAR_IDLE = 8'h01,
    BAR_WAIT_ACK = 8'h02,
    BAR_REF_ADDR = 8'h04,
    BAR_REF_RAS_A = 8'h08,
    BAR_REF_RAS_B = 8'h10,
    BAR_REF_END = 8'h20,
    BAR_DMA = 8'h40,
    BAR_RELEASE = 8'h80
  } bar_state_t;

  typedef enum logic [1:0] {
    BAR_OWN_NONE = 2'h0,
    BAR_OWN_REF = 2'h1,
    BAR_OWN_DMA = 2'h2
  } bar_owner_t;

  typedef struct packed {
    logic row_strobe0_n;
    logic row_strobe1_n;
    logic row_strobe2_n;
    logic row_strobe3_n;
  } bar_ras_t;

  typedef struct packed {
    logic action_code_bit1;
    logic action_code_bit0;
    logic action_code_en_n;
    logic addr_latch_en;
    logic ext_addr_latch_en;
  } bar_ac_t;

  typedef struct packed {
    bar_state_t st;
    bar_owner_t own;
    logic [`BAR_CNT_W-1:0] cnt;
    logic [`BAR_ROW_W-1:0] row;
    logic refresh_pend;
    logic dma_bus_request;
    logic refresh_active_n;
    logic dma_hold_ack;
    logic exp_mem_read_n;
    logic dram_write_en_n;
    logic addr_drive;
    bar_ras_t ras;
    bar_ac_t ac;
  } bar_state_all_t;

endpackage : bar_pkg

`default_nettype wire

// ### hw/bar_req_latch.sv
// Catches the active-low refresh request on the clock and holds it pending.
// Assumes the request is synchronous to the system clock.
`include "bar_map.svh"
`default_nettype none

module bar_req_latch
  import bar_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Request and acknowledge
  input wire logic i_req_n,
  input wire logic i_taken,
  output logic o_pending
);

  logic pend_q;
  logic pend_d;

  // A new request in the cycle it is taken keeps the flag set
  always_comb
  begin
    pend_d = pend_q;
    if (i_taken)
    begin
      pend_d = 1'b0;
    end
    if (!i_req_n)
    begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      pend_q <= 1'b0;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  assign o_pending = pend_q;

endmodule : bar_req_latch

`default_nettype wire

// ### test/bar_arbiter_bench.sv
// Self-checking bench for the bus arbiter with a processor model.
// Assumes bar_pkg, bar_map.svh and the checker are compiled alongside.
`include "bar_map.svh"
`default_nettype none

module bar_arbiter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic one; logic two; logic wr; logic [1:0] code;
    logic [3:0] lat;} bar_row_t;
  logic i_ref_clk, i_srst, i_cpu_bus_grant, i_cpu_exp_cycle, i_dma_hold_req;
  logic i_dma_addr_en_one, i_dma_addr_en_two, i_dma_mem_write, i_refresh_req_n;
  logic o_dma_bus_request, o_dma_hold_ack, o_refresh_active_n, o_dram_write_en_n;
  logic o_exp_mem_read_n, o_addr_drive, o_row_strobe0_n, o_row_strobe1_n;
  logic o_row_strobe2_n, o_row_strobe3_n, o_action_code_bit0, o_action_code_bit1;
  logic o_action_code_en_n, o_addr_latch_en, o_ext_addr_latch_en;
  logic [9:0] o_local_mem_addr, o_exp_bus_addr_low, r0;
  logic [3:0] lat;
  int num_errors, checks_done;
  bar_row_t rows [5] = '{'{1'b1, 1'b0, 1'b0, `BAR_AC_TRISTATE, 4'h0},
    '{1'b0, 1'b1, 1'b1, `BAR_AC_HI_WRITE, 4'h1}, '{1'b0, 1'b1, 1'b0, `BAR_AC_HI_READ, 4'h4},
    '{1'b1, 1'b1, 1'b1, `BAR_AC_TRISTATE, 4'h9}, '{1'b0, 1'b0, 1'b1, `BAR_AC_TRISTATE, 4'hf}};

  bar_arbiter dut (.*);
  bar_cpu_model cpu (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hold(o_dma_bus_request),
    .i_latency(lat), .o_grant(i_cpu_bus_grant));

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait: 0 ack, 1 refresh active, 2 processor grant
  task automatic wait_for(input int sel, input logic v);
    logic [2:0] s;
    for (int n = 0; n < 60; n++)
    begin
      @(negedge i_ref_clk);
      s = {i_cpu_bus_grant, o_refresh_active_n, o_dma_hold_ack};
      if (s[sel] === v)
        return;
    end
    chk(10'h0, 10'h1);
  endtask : wait_for

  task automatic dma(input bar_row_t r);
    @(posedge i_ref_clk);
    lat <= r.lat;
    i_dma_hold_req <= 1'b1;
    i_dma_addr_en_one <= r.one;
    i_dma_addr_en_two <= r.two;
    i_dma_mem_write <= r.wr;
    wait_for(0, 1'b1);
    chk({8'h0, o_action_code_bit1, o_action_code_bit0}, {8'h0, r.code});
    chk({7'h0, o_action_code_en_n, o_addr_latch_en, o_ext_addr_latch_en}, 10'h3);
    @(posedge i_ref_clk);
    i_dma_hold_req <= 1'b0;
    wait_for(2, 1'b0);
    chk({9'h0, o_dma_hold_ack}, 10'h1);
    wait_for(0, 1'b0);
  endtask : dma

  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  initial
  begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  initial
  begin
    repeat (5000) @(posedge i_ref_clk);
    num_errors++;
    close_out();
  end

  initial
  begin
    {i_srst, i_refresh_req_n} = 2'b11;
    {i_cpu_exp_cycle, i_dma_hold_req, i_dma_addr_en_one, i_dma_addr_en_two} = 4'h0;
    i_dma_mem_write = 1'b0;
    lat = 4'h2;
    num_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    foreach (rows[i])
      dma(rows[i]);
    $display("test dma codes done");
    r0 = o_local_mem_addr;
    @(posedge i_ref_clk);
    i_refresh_req_n <= 1'b0;
    @(posedge i_ref_clk);
    i_refresh_req_n <= 1'b1;
    @(negedge i_ref_clk);
    chk({9'h0, o_dma_bus_request}, 10'h0);
    @(negedge i_ref_clk);
    chk({9'h0, o_dma_bus_request}, 10'h1);
    wait_for(1, 1'b0);
    chk({8'h0, o_dram_write_en_n, o_dma_hold_ack}, 10'h2);
    wait_for(1, 1'b1);
    chk(o_local_mem_addr, r0 + 10'h1);
    chk(o_exp_bus_addr_low, r0 + 10'h1);
    chk({9'h0, o_dma_bus_request}, 10'h0);
    wait_for(2, 1'b0);
    $display("test refresh done");
    // Refresh pending when DMA is first seen must win
    @(posedge i_ref_clk);
    i_refresh_req_n <= 1'b0;
    @(posedge i_ref_clk);
    i_refresh_req_n <= 1'b1;
    i_dma_hold_req <= 1'b1;
    wait_for(1, 1'b0);
    chk({9'h0, o_dma_hold_ack}, 10'h0);
    wait_for(0, 1'b1);
    chk({9'h0, o_refresh_active_n}, 10'h1);
    $display("test refresh before dma done");
    @(posedge i_ref_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    i_dma_hold_req <= 1'b0;
    @(negedge i_ref_clk);
    chk({o_dma_bus_request, o_dma_hold_ack, o_refresh_active_n, o_exp_mem_read_n,
      o_row_strobe0_n, o_row_strobe1_n, o_row_strobe2_n, o_row_strobe3_n,
      o_dram_write_en_n, o_action_code_en_n}, 10'h0ff);
    chk(o_local_mem_addr, 10'h0);
    chk({5'h0, o_addr_drive, o_addr_latch_en, o_ext_addr_latch_en, o_action_code_bit1,
      o_action_code_bit0}, 10'h0);
    $display("test reset mid dma done");
    // Expansion cycle in idle turns the code enable on, a local one leaves it off
    @(posedge i_ref_clk);
    i_cpu_exp_cycle <= 1'b1;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk({9'h0, o_action_code_en_n}, 10'h0);
    @(posedge i_ref_clk);
    i_cpu_exp_cycle <= 1'b0;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk({9'h0, o_action_code_en_n}, 10'h1);
    $display("test expansion code enable done");
    close_out();
  end
endmodule : bar_arbiter_bench

`default_nettype wire

// ### test/bar_arbiter_chk.sv
// Port-level checker for the bus arbiter.
// Assumes one clock domain and the hand-over phase timing.
`default_nettype none

module bar_arbiter_chk
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Watched signals
  input wire logic i_cpu_bus_grant,
  input wire logic i_dma_hold_req,
  input wire logic i_refresh_req_n,
  input wire logic o_dma_bus_request,
  input wire logic o_dma_hold_ack,
  input wire logic o_refresh_active_n,
  input wire logic o_dram_write_en_n,
  input wire logic o_exp_mem_read_n,
  input wire logic o_addr_drive,
  input wire logic o_row_strobe0_n,
  input wire logic o_row_strobe1_n,
  input wire logic o_row_strobe2_n,
  input wire logic o_row_strobe3_n,
  input wire logic o_action_code_en_n,
  input wire logic o_addr_latch_en,
  input wire logic o_ext_addr_latch_en
);
  default clocking dc @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  a_hold_ref: assert property (
    $fell(i_refresh_req_n) && !o_dma_bus_request && !i_cpu_bus_grant && !o_dma_hold_ack
    |-> ##2 o_dma_bus_request) else $error("hold late after refresh request");
  a_grant_answer: assert property (
    o_dma_bus_request && i_cpu_bus_grant && o_refresh_active_n && !o_dma_hold_ack
    |=> !o_refresh_active_n || o_dma_hold_ack || !o_dma_bus_request) else $error("no grant");
  a_we_high: assert property (
    !o_refresh_active_n |-> o_dram_write_en_n) else $error("write enable low in refresh");
  a_addr_first: assert property (
    $fell(o_exp_mem_read_n) |-> o_addr_drive && $past(o_addr_drive)) else $error("addr late");
  a_precharge: assert property (
    $fell(o_refresh_active_n) |-> o_row_strobe0_n && o_row_strobe1_n && o_row_strobe2_n
    && o_row_strobe3_n) else $error("strobes low before refresh");
  a_ras_pairs: assert property (
    o_row_strobe0_n == o_row_strobe3_n && o_row_strobe1_n == o_row_strobe2_n)
    else $error("strobe pairs split");
  a_ras_stagger: assert property (
    $fell(o_row_strobe0_n) |-> o_row_strobe1_n ##2 $fell(o_row_strobe1_n))
    else $error("stagger wrong");
  a_read_width: assert property (
    $fell(o_exp_mem_read_n) |-> $fell(o_row_strobe0_n) ##12 $rose(o_exp_mem_read_n)
    && !o_refresh_active_n) else $error("read strobe width");
  a_ref_end: assert property (
    $rose(o_exp_mem_read_n) |-> !o_row_strobe0_n ##2 $rose(o_row_strobe0_n) && o_row_strobe1_n
    ##2 $fell(o_dma_bus_request)) else $error("refresh end order");
  a_ack_follow: assert property (
    o_dma_hold_ack |=> o_dma_hold_ack == $past(i_cpu_bus_grant)) else $error("ack wrong");
  a_drop_hold: assert property (
    o_dma_hold_ack && !i_dma_hold_req |=> !o_dma_bus_request) else $error("hold kept");
  a_ac_dma: assert property (
    o_dma_hold_ack |-> !o_action_code_en_n && o_addr_latch_en && o_ext_addr_latch_en)
    else $error("dma enables off");
endmodule : bar_arbiter_chk

bind bar_arbiter bar_arbiter_chk chk (.*);

`default_nettype wire

// ### test/bar_cpu_model.sv
// Processor stand-in: answers hold with a grant after a set latency.
// Assumes hold is synchronous to i_ref_clk.
`default_nettype none

module bar_cpu_model
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Hold handshake
  input wire logic i_hold,
  input wire logic [3:0] i_latency,
  output logic o_grant
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;

  // Latency stands for the processor finishing its current cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || !i_hold)
    begin
      wait_q <= 4'h0;
      o_grant <= 1'b0;
    end
    else if (wait_q >= i_latency)
      o_grant <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule : bar_cpu_model

`default_nettype wire
